/* File: rtl/usage_snapshot_defines.svh */
`ifndef USAGE_SNAPSHOT_DEFINES_SVH
`define USAGE_SNAPSHOT_DEFINES_SVH

// Register offsets inside each security space's feature frame.
`define OFF_USAGE_SNAPSHOT        12'h848
`define OFF_OVERFLOW_PENDING_MAP  12'h858

// Snapshot field layout.
`define SNAP_NOT_READY_BIT        31
`define SNAP_VALUE_MSB            30

// Monitor grouping for the overflow map.
`define MAP_GROUP_MASK            16'hFFE0
`define MAP_GROUP_SIZE            32

// Storage geometry: monitors per resource instance and resource instances.
`define MON_COUNT                 64
`define MON_IDX_W                 6
`define RIS_COUNT                 4
`define RIS_IDX_W                 2
`define SPACE_COUNT               4
`define SNAP_ADDR_W               10
`define SNAP_DEPTH                1024

// Reset values.
`define RDATA_RESET               32'h0000_0000

`endif

/* File: rtl/usage_snapshot_pkg.sv */
`include "usage_snapshot_defines.svh"

package usage_snapshot_pkg;

    // Security address frame through which an access arrives.
    typedef enum logic [1:0] {
        space_secure,
        space_nonsecure,
        space_root,
        space_realm
    } space_type;

    // What the read pipeline returns two cycles after the request.
    typedef enum logic [1:0] {
        kind_zero,
        kind_snapshot,
        kind_map
    } read_kind_type;

    // Snapshot storage index: space, resource instance, monitor.
    function automatic logic [`SNAP_ADDR_W-1:0] snap_index(
        input space_type                 space,
        input logic [`RIS_IDX_W-1:0]     resource_instance_select,
        input logic [`MON_IDX_W-1:0]     mon
    );
        snap_index = {space, resource_instance_select, mon};
    endfunction

endpackage

/* File: rtl/snapshot_store_if.sv */
`timescale 1ns/1ps
`include "usage_snapshot_defines.svh"

// Carries one write port and one registered read port of the store.
interface snapshot_store_if;
    logic                     wr_en;
    logic [`SNAP_ADDR_W-1:0]  wr_addr;
    logic [31:0]              wr_data;
    logic                     rd_en;
    logic [`SNAP_ADDR_W-1:0]  rd_addr;
    logic [31:0]              rd_data;

    modport owner (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_en,
        output rd_addr,
        input  rd_data
    );

    modport store (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  rd_en,
        input  rd_addr,
        output rd_data
    );
endinterface

/* File: rtl/snapshot_store.sv */
`timescale 1ns/1ps
`include "usage_snapshot_defines.svh"

module snapshot_store (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    snapshot_store_if.store    port
);

    logic [31:0]              mem [`SNAP_DEPTH];
    logic [`SNAP_DEPTH-1:0]   written;

    // The array carries no reset; the written flags make never-written
    // entries read as zero instead of unknown.
    always_ff @(posedge clk_sys) begin
        if (port.wr_en) begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    // Flags mark entries that hold a real value.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            written <= '0;
        end else if (port.wr_en) begin
            written[port.wr_addr] <= 1'b1;
        end
    end

    // Read-before-write: a read colliding with a write returns old data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port.rd_data <= `RDATA_RESET;
        end else if (port.rd_en) begin
            port.rd_data <= written[port.rd_addr] ? mem[port.rd_addr]
                                                  : `RDATA_RESET;
        end
    end

endmodule

/* File: rtl/cache_usage_snapshot_overflow.sv */
`timescale 1ns/1ps
`include "usage_snapshot_defines.svh"

// Functional notes
// - A 32-bit read/write snapshot shows the captured copy of the selected monitor.
// - Snapshot bit 31 is the captured not-ready flag; 1 means value may be wrong.
// - Snapshot bits 30:0 hold captured usage in bytes, valid only when ready.
// - Snapshot exists only with monitoring, usage monitors and capture; else reads zero.
// - With resource select, the selector's instance and monitor index pick the snapshot.
// - Without resource select, only the monitor index picks the snapshot.
// - Four separate snapshot sets, one per space, each using its own selector.
// - Snapshot sits at 0x848 per frame, read/write in Secure and Non-secure.
// - A 32-bit read-only map shows pending overflow for 32 aligned monitors.
// - Map bit i reports monitor (index AND 0xFFE0) plus i in the chosen instance.
// - Overflow map exists only when map support is set; else reads zero.
// - Separate overflow maps per space, reachable only from that space's frame.
// - Map sits at 0x858 per frame and is read-only, Root too with realm support.
// - Per-monitor accesses follow the selector of the space used to reach it.
module cache_usage_snapshot_overflow (
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst_n,
    input  wire logic                                  reg_req,
    input  wire logic                                  reg_write,
    input  wire usage_snapshot_pkg::space_type         reg_space,
    input  wire logic [11:0]                           reg_addr,
    input  wire logic [31:0]                           reg_wdata,
    output logic                                       reg_ack,
    output logic [31:0]                                reg_rdata,
    output logic                                       reg_rvalid,
    input  wire logic [3:0][15:0]                      sel_monitor_index,
    input  wire logic [3:0][3:0]                       sel_resource_instance,
    input  wire logic                                  capture_valid,
    input  wire usage_snapshot_pkg::space_type         capture_space,
    input  wire logic [`RIS_IDX_W-1:0]                 capture_ris,
    input  wire logic [`MON_IDX_W-1:0]                 capture_monitor,
    input  wire logic [30:0]                           capture_value,
    input  wire logic                                  capture_not_ready,
    input  wire logic [3:0][3:0][`MON_COUNT-1:0]       overflow_pending,
    input  wire logic                                  monitoring_supported,
    input  wire logic                                  usage_monitor_supported,
    input  wire logic                                  capture_supported,
    input  wire logic                                  overflow_map_supported,
    input  wire logic                                  resource_select_supported,
    input  wire logic                                  realm_extension_feature
);

    snapshot_store_if mif ();

    logic                                  snap_present;
    logic                                  frame_open;
    logic                                  frame_writable;
    logic [15:0]                           cur_index;
    logic [3:0]                            cur_ris_raw;
    logic [`RIS_IDX_W-1:0]                 cur_ris;
    logic                                  target_ok;
    logic [15:0]                           group_base;
    logic                                  hit_snap;
    logic                                  hit_map;
    logic                                  bus_take;
    logic                                  bus_read;
    logic                                  snap_wr;
    logic [31:0]                           next_map;
    usage_snapshot_pkg::read_kind_type     next_kind;
    usage_snapshot_pkg::read_kind_type     p1_kind;
    logic                                  p1_valid;
    logic [31:0]                           p1_map;

    snapshot_store u_store (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .port    (mif.store)
    );

    // Register presence and frame access rights from the feature straps.
    // Root and Realm frames exist only with the realm extension.
    assign snap_present = monitoring_supported && usage_monitor_supported
                          && capture_supported;
    assign frame_open   = (reg_space == usage_snapshot_pkg::space_secure)
                       || (reg_space == usage_snapshot_pkg::space_nonsecure)
                       || realm_extension_feature;
    assign frame_writable = frame_open;

    // The requesting space picks its own selector, never another's.
    assign cur_index   = sel_monitor_index[reg_space];
    assign cur_ris_raw = resource_select_supported
                         ? sel_resource_instance[reg_space]
                         : 4'h0;
    assign cur_ris     = cur_ris_raw[`RIS_IDX_W-1:0];
    // Monitors or instances beyond what is built read zero, ignore writes.
    assign target_ok   = (cur_index < 16'(`MON_COUNT))
                      && (cur_ris_raw < 4'(`RIS_COUNT));
    assign group_base  = cur_index & `MAP_GROUP_MASK;

    // Address decode, one match per register.
    always_comb begin
        hit_snap = 1'b0;
        hit_map  = 1'b0;
        if (reg_addr == `OFF_USAGE_SNAPSHOT) begin
            hit_snap = 1'b1;
        end else if (reg_addr == `OFF_OVERFLOW_PENDING_MAP) begin
            hit_map = 1'b1;
        end
    end

    // A capture owns the single store write port, so a software write
    // waits while capture_valid is high rather than being dropped or overwriting capture.
    assign reg_ack  = reg_req && !(reg_write && capture_valid);
    assign bus_take = reg_req && reg_ack;
    assign bus_read = bus_take && !reg_write;

    // Software write to the snapshot; the map never takes a write.
    assign snap_wr = bus_take && reg_write && hit_snap && snap_present
                  && frame_writable && target_ok;

    // Store write port: capture first, then software.
    always_comb begin
        mif.wr_en   = 1'b0;
        mif.wr_addr = '0;
        mif.wr_data = '0;
        if (capture_valid && snap_present) begin
            mif.wr_en   = 1'b1;
            mif.wr_addr = usage_snapshot_pkg::snap_index(capture_space,
                              capture_ris, capture_monitor);
            mif.wr_data = {capture_not_ready, capture_value};
        end else if (snap_wr) begin
            mif.wr_en   = 1'b1;
            mif.wr_addr = usage_snapshot_pkg::snap_index(reg_space,
                              cur_ris, cur_index[`MON_IDX_W-1:0]);
            mif.wr_data = reg_wdata;
        end
    end

    // Store read port follows the same index as the write side.
    assign mif.rd_en   = bus_read && hit_snap;
    assign mif.rd_addr = usage_snapshot_pkg::snap_index(reg_space,
                             cur_ris, cur_index[`MON_IDX_W-1:0]);

    // Overflow map word for the aligned group of 32 monitors.
    always_comb begin
        next_map = 32'h0000_0000;
        if (target_ok && (group_base[15:`MON_IDX_W] == '0)) begin
            if (group_base[`MON_IDX_W-1]) begin
                next_map = overflow_pending[reg_space][cur_ris][63:32];
            end else begin
                next_map = overflow_pending[reg_space][cur_ris][31:0];
            end
        end
    end

    // What the second stage will return for this read.
    always_comb begin
        next_kind = usage_snapshot_pkg::kind_zero;
        if (frame_open && hit_snap && snap_present && target_ok) begin
            next_kind = usage_snapshot_pkg::kind_snapshot;
        end else if (frame_open && hit_map && overflow_map_supported) begin
            next_kind = usage_snapshot_pkg::kind_map;
        end
    end

    // First read stage: the store is read and the map word is frozen.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            p1_valid <= 1'b0;
            p1_kind  <= usage_snapshot_pkg::kind_zero;
            p1_map   <= `RDATA_RESET;
        end else begin
            p1_valid <= bus_read;
            p1_kind  <= next_kind;
            p1_map   <= next_map;
        end
    end

    // Second read stage drives the registered read data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rvalid <= 1'b0;
            reg_rdata  <= `RDATA_RESET;
        end else begin
            reg_rvalid <= p1_valid;
            if (p1_valid) begin
                case (p1_kind)
                    usage_snapshot_pkg::kind_snapshot: begin
                        reg_rdata <= mif.rd_data;
                    end
                    usage_snapshot_pkg::kind_map: begin
                        reg_rdata <= p1_map;
                    end
                    default: begin
                        reg_rdata <= `RDATA_RESET;
                    end
                endcase
            end
        end
    end

    // Checks kept beside the logic.
    sequence s_snap_read;
        bus_read && hit_snap && snap_present && frame_open && target_ok;
    endsequence

    sequence s_map_read;
        bus_read && hit_map && overflow_map_supported && frame_open;
    endsequence

    a_read_latency: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        bus_read |-> ##2 reg_rvalid)
        else $error("Read data not returned two cycles after request.");

    a_no_stray_data: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rvalid |-> $past(bus_read, 2))
        else $error("Read valid without a matching request.");

    a_snap_roundtrip: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_snap_read ##1 1'b1 |=> reg_rdata == $past(mif.rd_data))
        else $error("Snapshot read did not return the stored word.");

    a_snap_absent_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        bus_read && hit_snap && !snap_present |-> ##2 reg_rdata == 32'h0)
        else $error("Absent snapshot read was not zero.");

    a_map_value: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_map_read |-> ##2 reg_rdata == $past(next_map, 2))
        else $error("Overflow map word differs from pending bits.");

    a_map_absent_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        bus_read && hit_map && !overflow_map_supported
            |-> ##2 reg_rdata == 32'h0)
        else $error("Absent overflow map read was not zero.");

    a_map_read_only: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mif.wr_en && !capture_valid |-> snap_wr && hit_snap && !hit_map)
        else $error("Store written by something other than a snapshot.");

    a_capture_copy: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        capture_valid && snap_present |-> mif.wr_en
            && mif.wr_data[31] == capture_not_ready
            && mif.wr_data[30:0] == capture_value)
        else $error("Capture did not copy flag and value together.");

    a_ris_ignored: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mif.rd_en && !resource_select_supported
            |-> mif.rd_addr[`MON_IDX_W +: `RIS_IDX_W] == '0)
        else $error("Resource instance used while not supported.");

    a_space_private: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mif.rd_en |-> mif.rd_addr[`SNAP_ADDR_W-1 -: 2] == reg_space)
        else $error("Snapshot read crossed into another space.");

    a_write_waits: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req && reg_write && capture_valid |-> !reg_ack)
        else $error("Write accepted while a capture owned the store.");

    sequence s_closed_write;
        bus_take && reg_write && !frame_writable && !capture_valid;
    endsequence

    a_closed_no_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_closed_write |-> !mif.wr_en)
        else $error("Write landed through a closed frame.");

    a_closed_read_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        bus_read && !frame_open |-> ##2 reg_rdata == 32'h0000_0000)
        else $error("Closed frame read was not zero.");

    a_unmapped_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        bus_read && !hit_snap && !hit_map
            |-> ##2 reg_rdata == 32'h0000_0000)
        else $error("Unmapped offset read was not zero.");

    a_range_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        bus_read && !target_ok |-> ##2 reg_rdata == 32'h0000_0000)
        else $error("Read beyond the built monitors was not zero.");

    a_rdata_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !p1_valid |=> $stable(reg_rdata))
        else $error("Read data changed without a read result.");

    a_ack_free: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req && !capture_valid |-> reg_ack)
        else $error("Request held off with no capture pending.");

endmodule

/* File: verif/sw_agent.sv */
`timescale 1ns/1ps

// Software side of the register bus. It makes one request at a time and
// holds it until the device acknowledges or 40 cycles pass. Released write, address and data
// lines are inverted so that no stale value can pass for a live one.
module sw_agent (
    input  wire logic                     clk_sys,
    input  wire logic                     reg_ack,
    input  wire logic [31:0]              reg_rdata,
    input  wire logic                     reg_rvalid,
    output logic                          reg_req,
    output logic                          reg_write,
    output usage_snapshot_pkg::space_type reg_space,
    output logic [11:0]                   reg_addr,
    output logic [31:0]                   reg_wdata
);
    int timeouts = 0;

    // The bus is idle from time zero.
    initial begin
        reg_req = 1'b0;
        reg_write = 1'b0;
        reg_space = usage_snapshot_pkg::space_secure;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
    end

    // One transfer; v holds the read strobe two and three cycles after take.
    task automatic xfer(
        input  logic                          wr,
        input  usage_snapshot_pkg::space_type sp,
        input  logic [11:0]                   a,
        input  logic [31:0]                   d,
        output logic [31:0]                   q,
        output logic [1:0]                    v
    );
        int n;
        @(negedge clk_sys);
        reg_req <= 1'b1;
        reg_write <= wr;
        reg_space <= sp;
        reg_addr <= a;
        reg_wdata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (reg_ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            timeouts++;
        end
        @(negedge clk_sys);
        reg_req <= 1'b0;
        reg_write <= ~wr;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(negedge clk_sys);
        v[1] = reg_rvalid;
        q = reg_rdata;
        @(negedge clk_sys);
        v[0] = reg_rvalid;
    endtask
endmodule

/* File: verif/tb_cache_usage_snapshot_overflow.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin \
    mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end

module tb_cache_usage_snapshot_overflow;
    logic                          clk_sys = 1'b0;
    logic                          rst_n = 1'b0;
    logic                          reg_req;
    logic                          reg_write;
    usage_snapshot_pkg::space_type reg_space;
    logic [11:0]                   reg_addr;
    logic [31:0]                   reg_wdata;
    logic                          reg_ack;
    logic [31:0]                   reg_rdata;
    logic                          reg_rvalid;
    logic [3:0][15:0]              sel_idx = '0;
    logic [3:0][3:0]               sel_ris = '0;
    logic                          cap_v = 1'b0;
    usage_snapshot_pkg::space_type cap_sp;
    logic [1:0]                    cap_ris = 2'h0;
    logic [5:0]                    cap_mon = 6'h00;
    logic [30:0]                   cap_val = 31'h0;
    logic                          cap_not_ready_flag = 1'b0;
    logic [3:0][3:0][63:0]         ovf = '0;
    logic [2:0]                    pres = 3'h7;
    logic                          omap = 1'b1;
    logic                          rsel = 1'b1;
    logic                          realm = 1'b1;
    logic [31:0]                   ref_mem [1024];
    integer                        seed = 32'hA3F44AE3;
    logic [31:0]                   r;
    logic [31:0]                   q;
    int                            checked = 0;
    int                            mismatches = 0;

    // Half period of 2.5 ns gives the 200 MHz system clock.
    always #2.5 clk_sys = ~clk_sys;

    cache_usage_snapshot_overflow i_dut (
        .clk_sys                   (clk_sys),
        .rst_n                     (rst_n),
        .reg_req                   (reg_req),
        .reg_write                 (reg_write),
        .reg_space                 (reg_space),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_ack                   (reg_ack),
        .reg_rdata                 (reg_rdata),
        .reg_rvalid                (reg_rvalid),
        .sel_monitor_index         (sel_idx),
        .sel_resource_instance     (sel_ris),
        .capture_valid             (cap_v),
        .capture_space             (cap_sp),
        .capture_ris               (cap_ris),
        .capture_monitor           (cap_mon),
        .capture_value             (cap_val),
        .capture_not_ready         (cap_not_ready_flag),
        .overflow_pending          (ovf),
        .monitoring_supported      (pres[0]),
        .usage_monitor_supported   (pres[1]),
        .capture_supported         (pres[2]),
        .overflow_map_supported    (omap),
        .resource_select_supported (rsel),
        .realm_extension_feature   (realm)
    );

    sw_agent i_sw (
        .clk_sys    (clk_sys),
        .reg_ack    (reg_ack),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid),
        .reg_req    (reg_req),
        .reg_write  (reg_write),
        .reg_space  (reg_space),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata)
    );

    // Storage slot that a frame's selector points at right now.
    function automatic int eidx(input int sp);
        int ri;
        ri = rsel ? int'(sel_ris[sp][1:0]) : 0;
        return sp * 256 + ri * 64 + int'(sel_idx[sp][5:0]);
    endfunction

    // Expected map word; groups starting past the last monitor read zero.
    function automatic logic [31:0] exp_map(input int sp);
        logic [15:0] b;
        b = sel_idx[sp] & 16'hFFE0;
        if (b >= 16'h0040) begin
            return 32'h0;
        end
        return ovf[sp][sel_ris[sp][1:0]][b[5:0] +: 32];
    endfunction

    // Writes never raise the read strobe; a read shows it for one cycle.
    task automatic acc(input logic wr, input int sp, input logic [11:0] a,
                       input logic [31:0] d);
        logic [1:0] v;
        i_sw.xfer(wr, usage_snapshot_pkg::space_type'(sp[1:0]), a, d, q, v);
        `CHK("read strobe timing", {~wr, 1'b0}, v)
    endtask

    task automatic chk_rd(input string n, input int sp,
                          input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, sp, a, 32'h0);
        `CHK(n, e, q)
    endtask

    task automatic done(input string n);
        $display("test %s done", n);
    endtask

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The whole run needs a few hundred cycles; twenty thousand is ample.
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    // Main sequence of tests.
    initial begin
        int sp;
        int k;
        for (k = 0; k < 1024; k++) begin
            ref_mem[k] = 32'h0;
        end
        cap_sp = usage_snapshot_pkg::space_secure;
        repeat (3) @(negedge clk_sys);
        `CHK("strobe in reset", 1'b0, reg_rvalid)
        rst_n = 1'b1;
        chk_rd("snapshot reset", 0, 12'h848, 32'h0);
        done("reset");
        // Same selector in all frames: only separate storage keeps them apart.
        for (k = 0; k < 8; k++) begin
            r = $random(seed);
            sel_idx = {4{10'h0, r[5:0]}};
            sel_ris = {4{2'b00, r[7:6]}};
            for (sp = 0; sp < 4; sp++) begin
                r = $random(seed);
                acc(1'b1, sp, 12'h848, r);
                ref_mem[eidx(sp)] = r;
            end
            for (sp = 0; sp < 4; sp++) begin
                chk_rd("snapshot", sp, 12'h848, ref_mem[eidx(sp)]);
            end
        end
        done("frames");
        // Captures alternate the not-ready flag so both values are seen.
        for (k = 0; k < 8; k++) begin
            r = $random(seed);
            sp = r[1:0];
            sel_idx[sp] = {10'h0, r[7:2]};
            sel_ris[sp] = {2'b00, r[9:8]};
            cap_sp = usage_snapshot_pkg::space_type'(r[1:0]);
            cap_ris = r[9:8];
            cap_mon = r[7:2];
            cap_val = 31'($random(seed));
            cap_not_ready_flag = k[0];
            cap_v = 1'b1;
            ref_mem[eidx(sp)] = {k[0], cap_val};
            @(negedge clk_sys);
            cap_v = 1'b0;
            cap_val = ~cap_val;
            chk_rd("capture", sp, 12'h848, ref_mem[eidx(sp)]);
        end
        // A write meeting a capture waits a cycle; both words must land.
        sel_idx[0] = 16'h0003;
        cap_sp = usage_snapshot_pkg::space_nonsecure;
        cap_mon = 6'h03;
        cap_ris = sel_ris[0][1:0];
        fork
            acc(1'b1, 0, 12'h848, 32'h0BAD_F00D);
            begin
                @(negedge clk_sys);
                cap_v = 1'b1;
                @(negedge clk_sys);
                cap_v = 1'b0;
            end
        join
        chk_rd("write waited", 0, 12'h848, 32'h0BAD_F00D);
        sel_idx[1] = 16'h0003;
        sel_ris[1] = sel_ris[0];
        chk_rd("capture kept", 1, 12'h848, {cap_not_ready_flag, cap_val});
        done("capture");
        rsel = 1'b0;
        sel_idx[1] = 16'h0005;
        sel_ris[1] = 4'h3;
        r = $random(seed);
        acc(1'b1, 1, 12'h848, r);
        ref_mem[eidx(1)] = r;
        sel_ris[1] = 4'h0;
        chk_rd("instance ignored", 1, 12'h848, r);
        rsel = 1'b1;
        sel_ris[1] = 4'h3;
        chk_rd("instance used", 1, 12'h848, ref_mem[eidx(1)]);
        done("instance select");
        for (k = 0; k < 3; k++) begin
            pres = 3'h7;
            pres[k] = 1'b0;
            acc(1'b1, 1, 12'h848, ~r);
            chk_rd("absent snapshot", 1, 12'h848, 32'h0);
        end
        pres = 3'h7;
        chk_rd("write ignored", 1, 12'h848, ref_mem[eidx(1)]);
        done("presence");
        for (k = 0; k < 32; k++) begin
            ovf[k / 8][(k / 2) % 4][(k % 2) * 32 +: 32] = $random(seed);
        end
        // Scan in steps of 32, as an overflow handler would.
        for (sp = 0; sp < 4; sp++) begin
            r = $random(seed);
            sel_ris[sp] = {2'b00, r[1:0]};
            for (k = 0; k < 3; k++) begin
                sel_idx[sp] = {11'h0, r[6:2]} + 16'(k * 32);
                chk_rd("overflow map", sp, 12'h858, exp_map(sp));
            end
        end
        sel_idx[0] = 16'h0021;
        acc(1'b1, 0, 12'h858, 32'hFFFF_FFFF);
        chk_rd("map read only", 0, 12'h858, exp_map(0));
        chk_rd("map write stray", 0, 12'h848, ref_mem[eidx(0)]);
        chk_rd("unmapped", 0, 12'h84C, 32'h0);
        sel_idx[2] = 16'h0000;
        omap = 1'b0;
        chk_rd("absent map", 2, 12'h858, 32'h0);
        omap = 1'b1;
        done("overflow map");
        realm = 1'b0;
        for (sp = 2; sp < 4; sp++) begin
            sel_idx[sp] = 16'h0000;
            acc(1'b1, sp, 12'h848, 32'h1234_5678);
            chk_rd("frame off snapshot", sp, 12'h848, 32'h0);
            chk_rd("frame off map", sp, 12'h858, 32'h0);
        end
        realm = 1'b1;
        chk_rd("root kept", 2, 12'h848, ref_mem[eidx(2)]);
        done("frames off");
        // A reset in mid-run must drop every stored word.
        acc(1'b1, 2, 12'h848, 32'h5A5A_5A5A);
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        chk_rd("reset clears", 2, 12'h848, 32'h0);
        done("mid reset");
        `CHK("ack timeouts", 0, i_sw.timeouts)
        tally_and_finish();
    end
endmodule
